// >>> tpm_consts.svh
// Purpose: constants for the trace port pin mux
// Assumes: pins numbered A0..A31=0..31, B0..B11=32..43, C0..C5=44..49, X0..X59=50..109
// Notes: trace tables hold 11 pin indices of 7 bits, signal 10 in the top slot
// Function
// - oscillator pins are reached through ordinary port function selection only while their power manager enable is off
// - power manager enables alone route each oscillator pin pair
// - enabled tracing owns its pins over port controller direction and function
// - three trace placements chosen by trace map select values zero, one, two
// - map two puts data bits 0..5 on port X 1..6; event out on B6
// - trace clock, six data bits and two frame bits are driven outputs
// - port X has sixty bidirectional lines numbered zero to fifty-nine
// - priority rises: port controller, trace, test port, oscillators
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH

`define TPM_PIN_COUNT   110
`define TPM_A_WIDTH     32
`define TPM_B_WIDTH     12
`define TPM_C_WIDTH     6
`define TPM_X_WIDTH     60
`define TPM_B_BASE      32
`define TPM_C_BASE      44
`define TPM_X_BASE      50
`define TPM_SIG_COUNT   11
`define TPM_IDX_W       7
`define TPM_SIG_EVTI    0
`define TPM_MAP_LAST    2'h2

// slot order 10..0: event out, clock, frame 1, frame 0, data 5..0, event in
`define TPM_MAP0 {7'h26, 7'h27, 7'h0a, 7'h0b, 7'h00, 7'h01, 7'h03, 7'h10, 7'h0d, 7'h0c, 7'h25}
`define TPM_MAP1 {7'h26, 7'h32, 7'h07, 7'h69, 7'h6a, 7'h6b, 7'h6c, 7'h18, 7'h17, 7'h16, 7'h08}
`define TPM_MAP2 {7'h26, 7'h29, 7'h3a, 7'h39, 7'h38, 7'h37, 7'h36, 7'h35, 7'h34, 7'h33, 7'h32}

// oscillator pad pairs on port C
`define TPM_OSC32_IN    7'h2c
`define TPM_OSC32_OUT   7'h2d
`define TPM_OSC0_IN     7'h2e
`define TPM_OSC0_OUT    7'h2f
`define TPM_OSC1_IN     7'h30
`define TPM_OSC1_OUT    7'h31

`endif

// >>> tpm_pkg.sv
// Purpose: shared types of the trace port pin mux
// Assumes: constants come from tpm_consts.svh
// Notes: none
`include "tpm_consts.svh"
package tpm_pkg;
  typedef logic [`TPM_PIN_COUNT-1:0] tpm_pins_t;
  typedef logic [`TPM_IDX_W-1:0]     tpm_idx_t;
  typedef logic [`TPM_SIG_COUNT*`TPM_IDX_W-1:0] tpm_table_t;

  typedef struct packed {
    tpm_pins_t  pad_out;
    tpm_pins_t  pad_oe;
    logic [5:0] analog_en;
    logic       event_in_n;
    logic       trace_active;
  } tpm_state_t;
endpackage : tpm_pkg

// >>> tpm_if.sv
// Purpose: carries trace requests to the map logic and pin claims back
// Assumes: one clock domain, combinational path only
// Notes: none
`timescale 1ns/100ps
interface tpm_if;
  logic              trace_enable;
  logic [1:0]        trace_map_select;
  logic              trace_clock_out;
  logic [5:0]        trace_message_data;
  logic [1:0]        trace_frame_control;
  logic              debug_event_out_n;
  tpm_pkg::tpm_pins_t claim;
  tpm_pkg::tpm_pins_t drive;
  tpm_pkg::tpm_pins_t drive_oe;
  tpm_pkg::tpm_idx_t  event_in_idx;
  logic              event_in_valid;

  modport map (
    input  trace_enable, trace_map_select, trace_clock_out,
    input  trace_message_data, trace_frame_control, debug_event_out_n,
    output claim, drive, drive_oe, event_in_idx, event_in_valid
  );
  modport top (
    output trace_enable, trace_map_select, trace_clock_out,
    output trace_message_data, trace_frame_control, debug_event_out_n,
    input  claim, drive, drive_oe, event_in_idx, event_in_valid
  );
endinterface : tpm_if

// >>> tpm_map.sv
// Purpose: turns trace enable and placement into pin claims and drive values
// Assumes: select value three is not a placement and claims nothing
// Notes: purely combinational; the top registers the result
`timescale 1ns/100ps
`include "tpm_consts.svh"
module tpm_map (
  // trace side and claims
  tpm_if.map ifc
);
  tpm_pkg::tpm_table_t tbl;
  logic [`TPM_SIG_COUNT-1:0] sig_val;
  logic                      map_ok;
  tpm_pkg::tpm_idx_t         idx;

  always_comb begin
    unique case (ifc.trace_map_select)
      2'h0: tbl = `TPM_MAP0;
      2'h1: tbl = `TPM_MAP1;
      2'h2: tbl = `TPM_MAP2;
      default: tbl = `TPM_MAP0;
    endcase
    map_ok = (ifc.trace_map_select <= `TPM_MAP_LAST);
    sig_val = {ifc.debug_event_out_n, ifc.trace_clock_out, ifc.trace_frame_control,
               ifc.trace_message_data, 1'b1};
    ifc.claim    = '0;
    ifc.drive    = '0;
    ifc.drive_oe = '0;
    idx          = '0;
    if (ifc.trace_enable && map_ok) begin
      for (int s = 0; s < `TPM_SIG_COUNT; s++) begin
        idx = tbl[s*`TPM_IDX_W +: `TPM_IDX_W];
        ifc.claim[idx]    = 1'b1;
        ifc.drive[idx]    = (s == `TPM_SIG_EVTI) ? 1'b0 : sig_val[s];
        ifc.drive_oe[idx] = (s != `TPM_SIG_EVTI);
      end
    end
    ifc.event_in_idx   = tbl[`TPM_SIG_EVTI*`TPM_IDX_W +: `TPM_IDX_W];
    ifc.event_in_valid = ifc.trace_enable && map_ok;
  end
endmodule : tpm_map

// >>> tpm_top.sv
// Purpose: pin ownership for ports A, B, C and X: port controller, trace, test port, oscillators
// Assumes: all inputs synchronous to clk_sys; pads resolve out/oe externally
// Notes: every pad output and enable is registered, so ownership changes one cycle late
`timescale 1ns/100ps
`include "tpm_consts.svh"
module tpm_top (
  // clock, reset, enable
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       ce,
  // port controller requests
  input  wire logic [`TPM_A_WIDTH-1:0]    gpio_a_out,
  input  wire logic [`TPM_A_WIDTH-1:0]    gpio_a_oe,
  input  wire logic [`TPM_B_WIDTH-1:0]    gpio_b_out,
  input  wire logic [`TPM_B_WIDTH-1:0]    gpio_b_oe,
  input  wire logic [`TPM_C_WIDTH-1:0]    gpio_c_out,
  input  wire logic [`TPM_C_WIDTH-1:0]    gpio_c_oe,
  input  wire logic [`TPM_X_WIDTH-1:0]    gpio_x_out,
  input  wire logic [`TPM_X_WIDTH-1:0]    gpio_x_oe,
  // pad input levels
  input  wire logic [`TPM_A_WIDTH-1:0]    pad_a_in,
  input  wire logic [`TPM_B_WIDTH-1:0]    pad_b_in,
  input  wire logic [`TPM_C_WIDTH-1:0]    pad_c_in,
  input  wire logic [`TPM_X_WIDTH-1:0]    pad_x_in,
  // test port claims, flat pin numbering
  input  wire logic [`TPM_PIN_COUNT-1:0]  test_claim,
  input  wire logic [`TPM_PIN_COUNT-1:0]  test_out,
  input  wire logic [`TPM_PIN_COUNT-1:0]  test_oe,
  // power manager oscillator enables: 0 osc0, 1 osc1, 2 osc32
  input  wire logic [2:0]                 power_manager_osc_en,
  // on-chip debug unit trace side
  input  wire logic                       trace_enable,
  input  wire logic [1:0]                 trace_map_select,
  input  wire logic                       trace_clock_out,
  input  wire logic [5:0]                 trace_message_data,
  input  wire logic [1:0]                 trace_frame_control,
  input  wire logic                       debug_event_out_n,
  output logic                            debug_event_in_n,
  output logic                            trace_active,
  // pad drive
  output logic [`TPM_A_WIDTH-1:0]         pad_a_out,
  output logic [`TPM_A_WIDTH-1:0]         pad_a_oe,
  output logic [`TPM_B_WIDTH-1:0]         pad_b_out,
  output logic [`TPM_B_WIDTH-1:0]         pad_b_oe,
  output logic [`TPM_C_WIDTH-1:0]         pad_c_out,
  output logic [`TPM_C_WIDTH-1:0]         pad_c_oe,
  output logic [`TPM_X_WIDTH-1:0]         pad_x_out,
  output logic [`TPM_X_WIDTH-1:0]         pad_x_oe,
  // oscillator analog hookup, bit n is port C line n
  output logic [5:0]                      osc_pad_analog_en
);

  tpm_pkg::tpm_state_t state_reg;
  tpm_pkg::tpm_state_t state_next;
  tpm_pkg::tpm_pins_t  gpio_out_all;
  tpm_pkg::tpm_pins_t  gpio_oe_all;
  tpm_pkg::tpm_pins_t  pad_in_all;
  tpm_pkg::tpm_pins_t  osc_claim;
  tpm_pkg::tpm_pins_t  upper_claim;

  tpm_if ifc ();

  // trace requests travel to the map logic unchanged
  assign ifc.trace_enable        = trace_enable;
  assign ifc.trace_map_select    = trace_map_select;
  assign ifc.trace_clock_out     = trace_clock_out;
  assign ifc.trace_message_data  = trace_message_data;
  assign ifc.trace_frame_control = trace_frame_control;
  assign ifc.debug_event_out_n   = debug_event_out_n;

  tpm_map u_map (
    .ifc (ifc.map)
  );

  // port X joins the flat pin vector
  assign gpio_out_all = {gpio_x_out, gpio_c_out, gpio_b_out, gpio_a_out};
  assign gpio_oe_all  = {gpio_x_oe, gpio_c_oe, gpio_b_oe, gpio_a_oe};
  assign pad_in_all   = {pad_x_in, pad_c_in, pad_b_in, pad_a_in};

  always_comb begin
    osc_claim = '0;
    osc_claim[`TPM_OSC0_IN]   = power_manager_osc_en[0];
    osc_claim[`TPM_OSC0_OUT]  = power_manager_osc_en[0];
    osc_claim[`TPM_OSC1_IN]   = power_manager_osc_en[1];
    osc_claim[`TPM_OSC1_OUT]  = power_manager_osc_en[1];
    osc_claim[`TPM_OSC32_IN]  = power_manager_osc_en[2];
    osc_claim[`TPM_OSC32_OUT] = power_manager_osc_en[2];
  end

  assign upper_claim = osc_claim | test_claim;

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < `TPM_PIN_COUNT; i++) begin
      if (osc_claim[i]) begin
        state_next.pad_out[i] = 1'b0;
        state_next.pad_oe[i]  = 1'b0;
      end else if (test_claim[i]) begin
        state_next.pad_out[i] = test_out[i];
        state_next.pad_oe[i]  = test_oe[i];
      end else if (ifc.claim[i]) begin
        state_next.pad_out[i] = ifc.drive[i];
        state_next.pad_oe[i]  = ifc.drive_oe[i];
      end else begin
        state_next.pad_out[i] = gpio_out_all[i];
        state_next.pad_oe[i]  = gpio_oe_all[i];
      end
    end
    state_next.analog_en = {power_manager_osc_en[1], power_manager_osc_en[1],
                            power_manager_osc_en[0], power_manager_osc_en[0],
                            power_manager_osc_en[2], power_manager_osc_en[2]};
    // an event input lost to a higher owner reads inactive, not the foreign level
    if (ifc.event_in_valid && !upper_claim[ifc.event_in_idx]) begin
      state_next.event_in_n = pad_in_all[ifc.event_in_idx];
    end else begin
      state_next.event_in_n = 1'b1;
    end
    state_next.trace_active = ifc.event_in_valid;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg.pad_out      <= '0;
      state_reg.pad_oe       <= '0;
      state_reg.analog_en    <= 6'h00;
      state_reg.event_in_n   <= 1'b1;
      state_reg.trace_active <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // placement two lands on port X lines via the registered vector
  assign pad_a_out = state_reg.pad_out[`TPM_A_WIDTH-1:0];
  assign pad_a_oe  = state_reg.pad_oe[`TPM_A_WIDTH-1:0];
  assign pad_b_out = state_reg.pad_out[`TPM_B_BASE +: `TPM_B_WIDTH];
  assign pad_b_oe  = state_reg.pad_oe[`TPM_B_BASE +: `TPM_B_WIDTH];
  assign pad_c_out = state_reg.pad_out[`TPM_C_BASE +: `TPM_C_WIDTH];
  assign pad_c_oe  = state_reg.pad_oe[`TPM_C_BASE +: `TPM_C_WIDTH];
  assign pad_x_out = state_reg.pad_out[`TPM_X_BASE +: `TPM_X_WIDTH];
  assign pad_x_oe  = state_reg.pad_oe[`TPM_X_BASE +: `TPM_X_WIDTH];

  assign osc_pad_analog_en = state_reg.analog_en;
  assign debug_event_in_n  = state_reg.event_in_n;
  assign trace_active      = state_reg.trace_active;

endmodule : tpm_top

// >>> tpm_chk_sva.sv
// Purpose: port checks of the trace pin mux
// Assumes: sees tpm_top ports only
// Notes: outputs follow their cause by one enabled edge
`timescale 1ns/100ps
module tpm_chk (
  // clock, reset, requests and results
  input logic         clk_sys,
  input logic         resetn,
  input logic         ce,
  input logic         trace_enable,
  input logic [1:0]   trace_map_select,
  input logic [5:0]   trace_message_data,
  input logic         debug_event_out_n,
  input logic [2:0]   power_manager_osc_en,
  input logic [109:0] test_claim,
  input logic [59:0]  gpio_x_oe,
  input logic [59:0]  pad_x_in,
  input logic [59:0]  pad_x_out,
  input logic [59:0]  pad_x_oe,
  input logic [11:0]  pad_b_out,
  input logic [5:0]   osc_pad_analog_en,
  input logic         trace_active,
  input logic         debug_event_in_n
);
  wire map_ok = trace_enable & (trace_map_select != 2'h3);
  wire map_two = ce & trace_enable & (trace_map_select == 2'h2);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_ACTIVE: assert property (ce |=> trace_active == $past(map_ok)) else $error("active wrong");
  AST_DATA: assert property (map_two && !(|test_claim[56:51]) |=>
    &pad_x_oe[6:1] && pad_x_out[6:1] == $past(trace_message_data)) else $error("data wrong");
  AST_EVTO: assert property (ce && map_ok && !test_claim[38] |=>
    pad_b_out[6] == $past(debug_event_out_n)) else $error("event out wrong");
  AST_EVTI: assert property (map_two && !test_claim[50] |=>
    !pad_x_oe[0] && debug_event_in_n == $past(pad_x_in[0])) else $error("event in wrong");
  AST_IDLE: assert property (ce && !map_ok |=> debug_event_in_n && !trace_active) else $error("idle wrong");
  AST_REL: assert property (ce && !trace_enable && test_claim == '0 |=>
    pad_x_oe == $past(gpio_x_oe)) else $error("release wrong");
  AST_OSC: assert property (ce && power_manager_osc_en[0] |=>
    osc_pad_analog_en[3:2] == 2'h3) else $error("osc not hooked");
  AST_NOOSC: assert property (ce && power_manager_osc_en == 3'h0 |=>
    osc_pad_analog_en == 6'h00) else $error("osc hooked");
  cover property (map_two);
  cover property (ce && power_manager_osc_en[0]);
  cover property (!ce && trace_active);
endmodule : tpm_chk
bind tpm_top tpm_chk u_chk (.*);

// >>> tpm_probe.sv
// Purpose: trace probe beyond the port X pads
// Assumes: released lines pulled high
// Notes: drives only the event-in line
`timescale 1ns/100ps
module tpm_probe (
  // pads and probe request
  input  logic [59:0] pad_x_out,
  input  logic [59:0] pad_x_oe,
  input  logic        event_level_n,
  output logic [59:0] pad_x_in
);
  assign pad_x_in = (pad_x_oe & pad_x_out) | (~pad_x_oe & {{59{1'b1}}, event_level_n});
endmodule : tpm_probe

// >>> tb.sv
// Purpose: self-checking bench of the trace pin mux
// Assumes: pads of ports A, B, C read low
// Notes: probe model resolves port X levels
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("FAIL %0t %h %h", $time, (a), (e)); end end
module tb;
  logic         clk_sys = 0, resetn = 0, ce = 1, trace_enable = 0, trace_clock_out = 0;
  logic         debug_event_out_n = 1, event_level_n = 1, debug_event_in_n, trace_active;
  logic [1:0]   trace_map_select = '0, trace_frame_control = '0;
  logic [2:0]   power_manager_osc_en = '0;
  logic [5:0]   trace_message_data = '0, gpio_c_out = '0, gpio_c_oe = '0, pad_c_in = '0;
  logic [5:0]   pad_c_out, pad_c_oe, osc_pad_analog_en;
  logic [11:0]  gpio_b_out = '0, gpio_b_oe = '0, pad_b_in = '0, pad_b_out, pad_b_oe;
  logic [31:0]  gpio_a_out = '0, gpio_a_oe = '0, pad_a_in = '0, pad_a_out, pad_a_oe;
  logic [59:0]  gpio_x_out = '0, gpio_x_oe = '0, pad_x_in, pad_x_out, pad_x_oe;
  logic [109:0] test_claim = '0, test_out = '0, test_oe = '0;
  int           miscompares = 0, total_checks = 0;
  tpm_top DUT (.*);
  tpm_probe probe (.pad_x_out, .pad_x_oe, .event_level_n, .pad_x_in);
  always #50 clk_sys = ~clk_sys;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic t_map2;
    @(posedge clk_sys);
    gpio_x_oe <= '1;
    {trace_enable, trace_map_select, trace_message_data, trace_frame_control} <= {1'b1, 2'h2, 6'h15, 2'h2};
    {trace_clock_out, debug_event_out_n, event_level_n} <= 3'h4;
    @(posedge clk_sys) #1;
    `CHK({pad_x_oe[8:0], pad_x_out[8:1]}, 17'h1_fe95)
    `CHK({pad_b_out[9], pad_b_oe[9], pad_b_out[6], pad_b_oe[6]}, 4'hd)
    `CHK({trace_active, debug_event_in_n}, 2'h2)
  endtask : t_map2
  task automatic t_maps;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      trace_map_select <= s[1:0];
      // event-in may sit where the last placement drove a trace output; let that driver go first
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK({pad_a_out[22], pad_a_out[12], pad_b_oe[9], pad_b_oe[7]}, {s == 1, s == 0, s == 2, s == 0})
      `CHK({trace_active, pad_b_oe[6], debug_event_in_n}, {s != 3, s != 3, s == 3})
    end
  endtask : t_maps
  task automatic t_prio;
    @(posedge clk_sys);
    {trace_map_select, test_claim[51], test_oe[51], gpio_c_oe, gpio_c_out, power_manager_osc_en} <= 19'h5_7ffd;
    @(posedge clk_sys) #1;
    `CHK({pad_x_oe[1], pad_x_out[1]}, 2'h0)
    `CHK({osc_pad_analog_en, pad_c_oe, pad_c_out}, 18'h0_fc30)
  endtask : t_prio
  task automatic t_release;
    @(posedge clk_sys);
    {ce, trace_enable, test_claim} <= '0;
    {gpio_a_out, gpio_a_oe, gpio_x_out} <= {31{4'h9}};
    @(posedge clk_sys) #1;
    `CHK(trace_active, 1'b1)
    @(posedge clk_sys);
    {ce, power_manager_osc_en} <= 4'h8;
    @(posedge clk_sys) #1;
    `CHK({pad_a_out, pad_a_oe, pad_x_out, pad_x_oe}, {gpio_a_out, gpio_a_oe, gpio_x_out, gpio_x_oe})
    `CHK({trace_active, debug_event_in_n, osc_pad_analog_en, pad_c_oe}, 14'h103f)
  endtask : t_release
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    t_map2;
    t_maps;
    t_prio;
    t_release;
    end_of_test;
  end
  initial begin
    #200_000 miscompares++;
    end_of_test;
  end
endmodule : tb
